// ===== core/uar_receiver.sv
// top of the asynchronous receive front end: pin synchroniser, start
// detection, per-bit majority vote, fifo and the plain register port.
// assumes a remote transmitter within the documented rate tolerance.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/1ns
module uar_receiver #(
  parameter int unsigned DIV_W = uar_pkg::DIV_W,
  parameter int unsigned FIFO_DEPTH = uar_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // serial line
  input wire logic serial_input_pin,
  output logic pin_override,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [15:0] reg_rdata
);
  typedef enum logic [1:0] {
    UAR_IDLE,
    UAR_START,
    UAR_BITS
  } uar_state_e;

  localparam int unsigned FW = uar_pkg::MAX_BITS + 1;

  logic [1:0] sync_reg;
  logic line;
  logic line_prev_reg;
  logic receiver_enable_bit;
  logic double_speed_select;
  logic [3:0] frame_bits_reg;
  logic [DIV_W-1:0] baud_divisor;
  logic tick;
  uar_state_e state_reg;
  logic [4:0] samp_reg;
  logic [3:0] bit_idx_reg;
  logic [1:0] votes_reg;
  logic [uar_pkg::MAX_BITS-1:0] shift_reg;
  logic push;
  logic [FW-1:0] push_data;
  logic fifo_full;
  logic [FW-1:0] head_data;
  logic rx_complete_flag;
  logic frame_error_flag;
  logic data_pop;
  logic [4:0] samp_last;
  logic [4:0] vote_first;
  logic voted;
  logic vote_done;
  logic bit_end;
  logic [3:0] frame_bits;

  function automatic logic majority(input logic [2:0] s);
    majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  // only the second stage feeds logic
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      sync_reg <= 2'h3;
    end else begin
      sync_reg <= {sync_reg[0], serial_input_pin};
    end
  end
  assign line = sync_reg[1];

  // control registers
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      receiver_enable_bit <= 1'b0;
      double_speed_select <= 1'b0;
      frame_bits_reg <= uar_pkg::BITS_RESET;
      baud_divisor <= DIV_W'(uar_pkg::DIV_RESET);
    end else if (reg_write && reg_addr == uar_pkg::OFS_CTRL) begin
      receiver_enable_bit <= reg_wdata[uar_pkg::CT_ENABLE];
      double_speed_select <= reg_wdata[uar_pkg::CT_DOUBLE];
      frame_bits_reg <= reg_wdata[uar_pkg::CT_BITS_LSB +: 4];
    end else if (reg_write && reg_addr == uar_pkg::OFS_DIVISOR) begin
      baud_divisor <= reg_wdata[DIV_W-1:0];
    end
  end

  // out-of-range lengths are clamped into 5..10
  assign frame_bits = (frame_bits_reg < 4'(uar_pkg::MIN_BITS)) ?
    4'(uar_pkg::MIN_BITS) :
    (frame_bits_reg > 4'(uar_pkg::MAX_BITS)) ? 4'(uar_pkg::MAX_BITS) :
    frame_bits_reg;

  assign pin_override = receiver_enable_bit;

  uar_tick_gen #(
    .DIV_W(DIV_W)
  ) u_tick (
    .clock(clock),
    .sys_rst(sys_rst),
    .run(receiver_enable_bit),
    .baud_divisor(baud_divisor),
    .tick(tick)
  );

  assign samp_last = double_speed_select ? 5'(uar_pkg::SAMP_DOUBLE) :
    5'(uar_pkg::SAMP_NORMAL);
  assign vote_first = double_speed_select ? uar_pkg::VOTE_FIRST_DOUBLE :
    uar_pkg::VOTE_FIRST_NORMAL;
  assign vote_done = tick && samp_reg == vote_first + 5'h02;
  assign bit_end = tick && samp_reg == samp_last;
  // samples one and two of the centre are held, the third is the live line
  assign voted = majority({votes_reg, line});

  always_ff @(posedge clock) begin
    if (sys_rst || !receiver_enable_bit) begin
      line_prev_reg <= 1'b1;
    end else if (tick) begin
      line_prev_reg <= line;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      votes_reg <= 2'h0;
    end else if (tick) begin
      votes_reg <= {votes_reg[0], line};
    end
  end

  // recovery state machine, samples numbered from one
  always_ff @(posedge clock) begin
    if (sys_rst || !receiver_enable_bit) begin
      // abandon any frame in progress at once
      state_reg <= UAR_IDLE;
      samp_reg <= 5'h00;
      bit_idx_reg <= 4'h0;
      shift_reg <= '0;
    end else if (tick) begin
      case (state_reg)
        UAR_IDLE: begin
          if (line_prev_reg && !line) begin
            state_reg <= UAR_START;
            samp_reg <= 5'h02;
          end
        end
        UAR_START: begin
          samp_reg <= (samp_reg == samp_last) ? 5'h01 : samp_reg + 5'h01;
          if (vote_done && voted) begin
            // noise spike, back to hunting
            state_reg <= UAR_IDLE;
            samp_reg <= 5'h00;
          end else if (samp_reg == samp_last) begin
            state_reg <= UAR_BITS;
            bit_idx_reg <= 4'h0;
          end
        end
        UAR_BITS: begin
          samp_reg <= (samp_reg == samp_last) ? 5'h01 : samp_reg + 5'h01;
          if (vote_done) begin
            if (bit_idx_reg == frame_bits) begin
              // first stop bit voted, hunt at once
              state_reg <= UAR_IDLE;
              samp_reg <= 5'h00;
            end else begin
              shift_reg[bit_idx_reg] <= voted;
            end
          end
          if (bit_end) begin
            bit_idx_reg <= bit_idx_reg + 4'h1;
          end
        end
        default: begin
          state_reg <= UAR_IDLE;
          samp_reg <= 5'h00;
        end
      endcase
    end
  end

  // stop bit voted zero marks a frame error
  assign push = receiver_enable_bit && state_reg == UAR_BITS && vote_done &&
    bit_idx_reg == frame_bits;
  assign push_data = {!voted, shift_reg};

  assign data_pop = reg_read && reg_addr == uar_pkg::OFS_DATA;

  uar_rx_fifo #(
    .WIDTH(FW),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clock(clock),
    .sys_rst(sys_rst),
    .flush(!receiver_enable_bit),
    .push(push),
    .push_data(push_data),
    .full(fifo_full),
    .pop(data_pop),
    .head_data(head_data),
    .not_empty(rx_complete_flag)
  );

  assign frame_error_flag = rx_complete_flag && head_data[FW-1];

  // read data one cycle after the strobe; software drains by reading
  // data until the complete flag drops
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_read) begin
      case (reg_addr)
        uar_pkg::OFS_DATA:
          reg_rdata <= rx_complete_flag ?
            16'(head_data[uar_pkg::MAX_BITS-1:0]) : 16'h0000;
        uar_pkg::OFS_STATUS:
          reg_rdata <= {14'h0000, frame_error_flag, rx_complete_flag};
        uar_pkg::OFS_CTRL:
          reg_rdata <= {8'h00, frame_bits_reg, 2'h0, double_speed_select,
            receiver_enable_bit};
        uar_pkg::OFS_DIVISOR:
          reg_rdata <= 16'(baud_divisor);
        default:
          reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  chk_disable_idle: assert property (@(posedge clock) disable iff (sys_rst)
    !receiver_enable_bit |=> state_reg == UAR_IDLE && !rx_complete_flag)
    else $error("receiver active while disabled");
  chk_noise_reject: assert property (@(posedge clock) disable iff (sys_rst)
    state_reg == UAR_START && vote_done && voted && receiver_enable_bit
    |=> state_reg == UAR_IDLE)
    else $error("noisy start bit not rejected");
  chk_sample_range: assert property (@(posedge clock) disable iff (sys_rst)
    state_reg != UAR_IDLE |-> samp_reg >= 5'h01 && samp_reg <= samp_last)
    else $error("sample number out of range");
  chk_stop_hunt: assert property (@(posedge clock) disable iff (sys_rst)
    push |=> state_reg == UAR_IDLE && samp_reg == 5'h00)
    else $error("not hunting after stop vote");
  chk_frame_error: assert property (@(posedge clock)
    disable iff (sys_rst)
    push && !fifo_full && !rx_complete_flag && !data_pop
    |=> frame_error_flag == !$past(voted))
    else $error("frame error not stored with character");
  chk_complete_flag: assert property (@(posedge clock) disable iff (sys_rst)
    push && !fifo_full && receiver_enable_bit |=> rx_complete_flag)
    else $error("complete flag not raised");
  chk_start_number: assert property (@(posedge clock) disable iff (sys_rst)
    state_reg == UAR_IDLE && tick && line_prev_reg && !line &&
    receiver_enable_bit |=> state_reg == UAR_START && samp_reg == 5'h02)
    else $error("start edge not numbered");
  chk_bit_count: assert property (@(posedge clock) disable iff (sys_rst)
    state_reg == UAR_BITS |-> bit_idx_reg <= frame_bits)
    else $error("recovered past first stop bit");
endmodule

// ===== core/uar_pkg.sv
// package for the asynchronous receive front end: frame limits, sample
// numbers, fifo geometry and register offsets.
// assumes a single 125 MHz clock and a synchronous active-high reset.
//
// Notes on behaviour
// - receiver off empties fifo and drops status
// - sixteen samples per bit, eight at double
// - first low sample after idle is one
// - start vote on samples 8-10 or 4-6
// - two highs in start vote means noise
// - sample counter realigned on every start bit
// - three recovery states, sample number kept in a counter
// - each bit is majority of centre three
// - only the first stop bit is recovered
// - stop bit voted zero sets frame error
// - hunt for next start right after vote
// - double speed select halves the oversampling
// - five to ten data-plus-parity bits accepted
// - complete flag is fifo not empty
// - frame error travels with its character
// - disable is immediate and releases the pin
package uar_pkg;
  localparam int unsigned CLK_HZ = 125000000;
  localparam int unsigned MIN_BITS = 5;
  localparam int unsigned MAX_BITS = 10;
  localparam int unsigned BITS_W = 4;
  localparam int unsigned SAMP_NORMAL = 16;
  localparam int unsigned SAMP_DOUBLE = 8;
  // centre samples, first of three
  localparam logic [4:0] VOTE_FIRST_NORMAL = 5'h08;
  localparam logic [4:0] VOTE_FIRST_DOUBLE = 5'h04;
  localparam int unsigned FIFO_DEPTH = 2;
  localparam int unsigned DIV_W = 12;
  localparam logic [11:0] DIV_RESET = 12'h000;
  localparam logic [3:0] BITS_RESET = 4'h8;
  // register offsets on the plain port
  localparam logic [3:0] OFS_DATA = 4'h0;
  localparam logic [3:0] OFS_STATUS = 4'h1;
  localparam logic [3:0] OFS_CTRL = 4'h2;
  localparam logic [3:0] OFS_DIVISOR = 4'h3;
  // status fields
  localparam int unsigned ST_COMPLETE = 0;
  localparam int unsigned ST_FRAME_ERR = 1;
  // control fields
  localparam int unsigned CT_ENABLE = 0;
  localparam int unsigned CT_DOUBLE = 1;
  localparam int unsigned CT_BITS_LSB = 4;
endpackage

// ===== core/uar_tick_gen.sv
// baud tick divider: one-cycle enable every divisor+1 clocks.
// assumes divisor is stable while receiving; a change does not restart the count.
`timescale 1ns/1ns
module uar_tick_gen #(
  parameter int unsigned DIV_W = 12
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // control
  input wire logic run,
  input wire logic [DIV_W-1:0] baud_divisor,
  // sample tick
  output logic tick
);
  logic [DIV_W-1:0] cnt_reg;

  always_ff @(posedge clock) begin
    if (sys_rst || !run || cnt_reg >= baud_divisor) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  assign tick = run && (cnt_reg >= baud_divisor);

  chk_tick_spacing: assert property (@(posedge clock) disable iff (sys_rst)
    tick && baud_divisor != '0 && $stable(baud_divisor) |=> !tick)
    else $error("tick fired two cycles in a row");
endmodule

// ===== core/uar_rx_fifo.sv
// small receive fifo for character plus frame error, register read data.
// a push when full is ignored here, so the new frame is dropped.
`timescale 1ns/1ns
module uar_rx_fifo #(
  parameter int unsigned WIDTH = 11,
  parameter int unsigned DEPTH = 2
) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic flush,
  // write side
  input wire logic push,
  input wire logic [WIDTH-1:0] push_data,
  output logic full,
  // read side
  input wire logic pop,
  output logic [WIDTH-1:0] head_data,
  output logic not_empty
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_reg;
  logic [AW-1:0] rd_reg;
  logic [AW:0] cnt_reg;
  logic do_push;
  logic do_pop;
  logic [AW-1:0] rd_next;
  logic [AW:0] cnt_left;

  assign full = (cnt_reg == (AW+1)'(DEPTH));
  assign not_empty = (cnt_reg != '0);
  assign do_push = push && !full;
  assign do_pop = pop && not_empty;
  assign rd_next = !do_pop ? rd_reg :
    (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
  assign cnt_left = cnt_reg - (AW+1)'(do_pop);

  always_ff @(posedge clock) begin
    if (do_push) begin
      mem[wr_reg] <= push_data;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst || flush) begin
      wr_reg <= '0;
      rd_reg <= '0;
      cnt_reg <= '0;
    end else begin
      if (do_push) begin
        wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
      end
      if (do_pop) begin
        rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
      end
      cnt_reg <= cnt_reg + (AW+1)'(do_push) - (AW+1)'(do_pop);
    end
  end

  // the head follows the next read pointer, so status read in the cycle
  // after a push or a pop already belongs to the new head
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      head_data <= '0;
    end else if (do_push && cnt_left == '0) begin
      head_data <= push_data;
    end else begin
      head_data <= mem[rd_next];
    end
  end

  chk_flush_empties: assert property (@(posedge clock) disable iff (sys_rst)
    flush |=> !not_empty)
    else $error("fifo not empty after flush");
endmodule

// ===== dv/uar_serial_tx.sv
// behavioural remote transmitter driving the receive line of the receiver.
// assumes tasks are called one at a time, just after a rising clock edge.
`timescale 1ns/1ns
module uar_serial_tx (
  // clock
  input wire logic clock,
  // serial line, idle high
  output logic line
);
  initial line = 1'b1;

  task automatic drive(input logic v, input int n);
    line <= v;
    repeat (n) @(posedge clock);
  endtask

  // bit period in clocks sets the sender rate against the receiver
  // glitch flips samples 7 and 8 of a bit: only one of them is voted
  task automatic send(input logic [9:0] d, input int nb, input int bc,
      input logic sb, input int sc, input logic gl);
    drive(1'b0, bc);
    for (int i = 0; i < nb; i++) begin
      if (gl) begin
        drive(d[i], bc / 2 - 4);
        drive(!d[i], 4);
        drive(d[i], bc - bc / 2);
      end else begin
        drive(d[i], bc);
      end
    end
    drive(sb, sc);
    // short idle so a following frame never drives twice in one step
    drive(1'b1, 2);
  endtask

  task automatic spike(input int n);
    drive(1'b0, n);
    drive(1'b1, 2);
  endtask
endmodule

// ===== dv/tb.sv
// self-checking bench for the receive front end with a queue model.
// assumes divisor 1, so one sample every two clocks and 32-clock bits, 16 at double speed.
`timescale 1ns/1ns
module tb;
  logic clock, sys_rst, serial_input_pin, pin_override;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rd;
  logic reg_write, reg_read;
  logic [9:0] msk;
  logic [10:0] q[$];
  int fails = 0;
  int total_checks = 0;
  int cyc = 0;

  uar_receiver u_dut (.clock(clock), .sys_rst(sys_rst),
    .serial_input_pin(serial_input_pin), .pin_override(pin_override),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata));
  uar_serial_tx u_tx (.clock(clock), .line(serial_input_pin));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ceiling well above the roughly 6k cycles the sequence needs
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      fails++;
      $display("MISMATCH timeout exp done got hang");
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [15:0] e,
      input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask

  task automatic rdr(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic cfg(input int nb, input logic db, input logic en);
    msk = 10'((1 << nb) - 1);
    wr(uar_pkg::OFS_CTRL, {8'h00, 4'(nb), 2'b00, db, en});
    if (!en) q.delete();
  endtask

  task automatic frame(input int nb, input int bc, input logic sb,
      input int sc, input logic gl);
    logic [9:0] d;
    d = 10'($urandom);
    u_tx.send(d, nb, bc, sb, sc, gl);
    // a full fifo drops the new frame
    if (q.size() < uar_pkg::FIFO_DEPTH) q.push_back({!sb, d & msk});
  endtask

  // status first, then data, as the head moves on a data read
  task automatic drain();
    logic [15:0] e;
    e = (q.size() != 0) ? {14'h0, q[0][10], 1'b1} : 16'h0000;
    rdr(uar_pkg::OFS_STATUS, rd);
    chk("status", e, {14'h0, rd[1:0]});
    e = (q.size() != 0) ? {6'h0, q[0][9:0]} : 16'h0000;
    rdr(uar_pkg::OFS_DATA, rd);
    chk("data", e, {6'h0, rd[9:0] & msk});
    if (q.size() != 0) void'(q.pop_front());
  endtask

  initial begin
    int bc;
    void'($urandom(32'h9aa12508));
    sys_rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_write = 1'b0;
    reg_read = 1'b0;
    msk = 10'h3ff;
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    rdr(uar_pkg::OFS_STATUS, rd);
    chk("status rst", 16'h0000, rd);
    chk("pin rst", 16'h0000, {15'h0, pin_override});
    rdr(4'h7, rd);
    chk("unmapped", 16'h0000, rd);
    wr(uar_pkg::OFS_DIVISOR, 16'h0001);
    for (int db = 0; db < 2; db++) begin
      for (int nb = 5; nb <= 10; nb++) begin
        cfg(nb, 1'(db), 1'b1);
        repeat ($urandom_range(40, 2)) @(posedge clock);
        bc = (db != 0) ? 16 : 31 + nb % 3;
        frame(nb, bc, 1'b1, bc, 1'b0);
        repeat (8) @(posedge clock);
        drain();
        drain();
      end
    end
    cfg(8, 1'b0, 1'b1);
    @(posedge clock);
    #1 chk("pin on", 16'h0001, {15'h0, pin_override});
    frame(8, 32, 1'b0, 32, 1'b0);
    repeat (20) @(posedge clock);
    frame(8, 32, 1'b1, 32, 1'b1);
    repeat (8) @(posedge clock);
    repeat (3) drain();
    repeat (3) frame(8, 32, 1'b1, 24, 1'b0);
    repeat (8) @(posedge clock);
    repeat (3) drain();
    u_tx.spike(6);
    repeat (60) @(posedge clock);
    drain();
    frame(8, 32, 1'b1, 32, 1'b0);
    frame(8, 32, 1'b1, 32, 1'b0);
    cfg(8, 1'b0, 1'b0);
    @(posedge clock);
    #1 chk("pin off", 16'h0000, {15'h0, pin_override});
    rdr(uar_pkg::OFS_STATUS, rd);
    chk("flushed", 16'h0000, rd);
    cfg(8, 1'b0, 1'b1);
    fork
      u_tx.send(10'h155, 8, 32, 1'b1, 32, 1'b0);
      begin
        repeat (120) @(posedge clock);
        cfg(8, 1'b0, 1'b0);
      end
    join
    cfg(8, 1'b0, 1'b1);
    drain();
    frame(8, 32, 1'b1, 32, 1'b0);
    repeat (8) @(posedge clock);
    drain();
    stop_test();
  end
endmodule
